// file: lnbsc_host_model.sv
`timescale 1ns/100ps
module lnbsc_host_model (
  // clock
  input  wire logic clk,
  // bus lines
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_m
);
  // bus idles high, clock stands still outside frames
  initial begin
    scl   = 1'b1;
    sda_m = 1'b1;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask

  // one bit: data set in low phase, line sampled mid-high
  task automatic bit_io(input logic b, output logic r);
    wait_clk(1);
    sda_m = b;
    wait_clk(3);
    scl = 1'b1;
    wait_clk(2);
    r = sda_line;
    wait_clk(2);
    scl = 1'b0;
  endtask

  // also serves as repeated start
  task automatic start();
    wait_clk(1);
    sda_m = 1'b1;
    wait_clk(3);
    scl = 1'b1;
    wait_clk(4);
    sda_m = 1'b0;
    wait_clk(4);
    scl = 1'b0;
  endtask

  task automatic stop();
    wait_clk(1);
    sda_m = 1'b0;
    wait_clk(3);
    scl = 1'b1;
    wait_clk(4);
    sda_m = 1'b1;
    wait_clk(4);
  endtask

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  // master acks to continue, nacks to end the read
  task automatic rd_byte(input logic ack_m, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(~ack_m, r);
  endtask
endmodule

// file: lnbsc_lim_if.sv
`timescale 1ns/100ps
interface lnbsc_lim_if;
  logic enable;
  logic static_mode;
  logic overload;
  logic hold;
  logic flag;
  logic output_off;

  modport core (
    output enable, static_mode, overload, hold,
    input  flag, output_off
  );
  modport limiter (
    input  enable, static_mode, overload, hold,
    output flag, output_off
  );
endinterface

// file: lnbsc_limiter.sv
`timescale 1ns/100ps
module lnbsc_limiter
  import lnbsc_pkg::*;
#(
  parameter int unsigned T_OFF_CYC = T_OFF_CYCLES,
  parameter int unsigned T_ON_CYC  = T_ON_CYCLES
) (
  // clock and reset
  input  wire logic   clk,
  input  wire logic   resetn,
  // link to the core
  lnbsc_lim_if.limiter lim
);

  typedef enum logic [1:0] {LIM_OK, LIM_OFF, LIM_ON} lnbsc_lim_t;

  localparam logic [LIM_CNT_W-1:0] OFF_LAST = LIM_CNT_W'(T_OFF_CYC - 1);
  localparam logic [LIM_CNT_W-1:0] ON_LAST  = LIM_CNT_W'(T_ON_CYC - 1);

  lnbsc_lim_t           state_q, state_d;
  logic [LIM_CNT_W-1:0] cnt_q, cnt_d;
  logic                 flag_q, flag_d;
  logic                 seen_q, seen_d;
  wire                  active = lim.enable & ~lim.hold;
  wire                  dyn    = active & ~lim.static_mode;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    flag_d  = flag_q;
    seen_d  = seen_q;
    if (!active) begin
      state_d = LIM_OK;
      cnt_d   = '0;
      flag_d  = 1'b0;
      seen_d  = 1'b0;
    end else if (lim.static_mode) begin
      state_d = LIM_OK;
      cnt_d   = '0;
      flag_d  = lim.overload;
      seen_d  = 1'b0;
    end else begin
      case (state_q)
        LIM_OK: if (lim.overload) begin
          state_d = LIM_OFF;
          cnt_d   = '0;
          flag_d  = 1'b1;
        end
        LIM_OFF: if (cnt_q == OFF_LAST) begin
          state_d = LIM_ON;
          cnt_d   = '0;
          seen_d  = 1'b0;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
        LIM_ON: begin
          seen_d = seen_q | lim.overload;
          if (cnt_q == ON_LAST) begin
            cnt_d = '0;
            if (seen_q | lim.overload) begin
              state_d = LIM_OFF;
            end else begin
              state_d = LIM_OK;
              flag_d  = 1'b0;
            end
          end else begin
            cnt_d = cnt_q + 1'b1;
          end
        end
        default: state_d = LIM_OK;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= LIM_OK;
      cnt_q   <= '0;
      flag_q  <= 1'b0;
      seen_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      flag_q  <= flag_d;
      seen_q  <= seen_d;
    end
  end

  assign lim.flag       = flag_q;
  assign lim.output_off = (state_q == LIM_OFF);

  property p_dyn_trip;
    @(posedge clk) disable iff (!resetn)
    dyn && state_q == LIM_OK && lim.overload |=> flag_q && lim.output_off;
  endproperty
  a_dyn_trip: assert property (p_dyn_trip)
    else $error("dynamic overload did not trip");

  property p_dyn_clear;
    @(posedge clk) disable iff (!resetn)
    dyn && state_q == LIM_ON && cnt_q == ON_LAST && !seen_q && !lim.overload
    |=> !flag_q && state_q == LIM_OK;
  endproperty
  a_dyn_clear: assert property (p_dyn_clear)
    else $error("overload flag not cleared after clean on-period");

  property p_static_follow;
    @(posedge clk) disable iff (!resetn)
    active && lim.static_mode |=> flag_q == $past(lim.overload) && !lim.output_off;
  endproperty
  a_static_follow: assert property (p_static_follow)
    else $error("static mode flag does not follow clamp");

endmodule

// file: lnbsc_pkg.sv
package lnbsc_pkg;

  // clock and protection timing
  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam int unsigned T_OFF_MS     = 900;
  localparam int unsigned T_ON_MS      = 20;
  localparam int unsigned T_OFF_CYCLES = T_OFF_MS * (CLK_HZ / 1000);
  localparam int unsigned T_ON_CYCLES  = T_ON_MS * (CLK_HZ / 1000);
  localparam int unsigned LIM_CNT_W    = 24;

  // bus framing
  localparam logic [6:0] SLAVE_ADDR_BASE = 7'h08;
  localparam logic [3:0] BYTE_BITS       = 4'h8;

  // supply_control_status fields
  localparam int unsigned BIT_SEL   = 7;
  localparam int unsigned BIT_DCL   = 6;
  localparam int unsigned BIT_SPARE = 5;
  localparam int unsigned BIT_ENT   = 4;
  localparam int unsigned BIT_LLC   = 3;
  localparam int unsigned BIT_VOLTAGE_SELECT  = 2;
  localparam int unsigned BIT_EN    = 1;
  localparam int unsigned BIT_OLF   = 0;
  // thermal_status fields
  localparam int unsigned BIT_OTF   = 1;

  // reset values and writable masks
  localparam logic [7:0] REG_RESET     = 8'h00;
  localparam logic [7:0] CTRL_WR_MASK  = 8'h7E;
  localparam logic [7:0] THERM_WR_MASK = 8'h7D;

  // output target codes, {length_compensation, voltage_select}
  localparam logic [1:0] VOUT_13V = 2'h0;
  localparam logic [1:0] VOUT_18V = 2'h1;
  localparam logic [1:0] VOUT_14V = 2'h2;
  localparam logic [1:0] VOUT_19V = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WRITE, ST_WRITE_ACK, ST_READ, ST_READ_ACK
  } lnbsc_bus_t;

endpackage

// file: lnbsc_sync.sv
`timescale 1ns/100ps
module lnbsc_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  // raw inputs and synchronised copies
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// file: lnbsc_top.sv
`timescale 1ns/100ps
module lnbsc_top
  import lnbsc_pkg::*;
#(
  parameter int unsigned T_OFF_CYC = T_OFF_CYCLES,
  parameter int unsigned T_ON_CYC  = T_ON_CYCLES
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // two-wire bus, open drain
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  // strap and supervisor inputs
  input  wire logic       addr_sel,
  input  wire logic       power_good,
  input  wire logic       tone_modulation_input,
  input  wire logic       overload_detect,
  input  wire logic       overtemp_detect,
  // power stage control
  output logic            supply_enable,
  output logic            boost_enable,
  output logic            linreg_enable,
  output logic [1:0]      vout_code,
  output logic            tone_on,
  output logic            static_limit
);

  // synchronised pins
  logic [6:0] pins_s;
  wire        scl_s  = pins_s[6];
  wire        sda_s  = pins_s[5];
  wire        asel_s = pins_s[4];
  wire        pg_s   = pins_s[3];
  wire        tone_s = pins_s[2];
  wire        ovl_s  = pins_s[1];
  wire        ovt_s  = pins_s[0];

  lnbsc_sync #(
    .W (7)
  ) u_sync (
    .clk      (clk),
    .resetn   (resetn),
    .async_in ({scl_i, sda_i, addr_sel, power_good,
                tone_modulation_input, overload_detect, overtemp_detect}),
    .sync_out (pins_s)
  );

  // bus engine state
  lnbsc_bus_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] shift_q, shift_d;
  logic [7:0] tx_q, tx_d;
  logic       oe_q, oe_d;
  logic       ack_q, ack_d;
  logic       rw_q, rw_d;
  logic       scl_q, sda_q;
  // register state
  logic       sel_q, sel_d;
  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] therm_q, therm_d;

  lnbsc_lim_if lim ();

  lnbsc_limiter #(
    .T_OFF_CYC (T_OFF_CYC),
    .T_ON_CYC  (T_ON_CYC)
  ) u_limiter (
    .clk    (clk),
    .resetn (resetn),
    .lim    (lim.limiter)
  );

  // line events
  wire scl_rise  = scl_s & ~scl_q;
  wire scl_fall  = ~scl_s & scl_q;
  wire start_det = scl_s & scl_q & sda_q & ~sda_s;
  wire stop_det  = scl_s & scl_q & ~sda_q & sda_s;
  wire byte_done = (cnt_q == BYTE_BITS);

  // address decode
  wire [6:0] own_addr = SLAVE_ADDR_BASE | {6'h00, asel_s};
  wire       addr_hit = (shift_q[7:1] == own_addr);

  // register views
  wire overtemperature_flag = ovt_s;
  wire overload_flag = lim.flag;
  wire [7:0] ctrl_rd  = (ctrl_q & CTRL_WR_MASK) | {7'h00, overload_flag};
  wire [7:0] therm_rd = (therm_q & THERM_WR_MASK) | 8'h80
                      | {6'h00, overtemperature_flag, 1'b0};
  wire [7:0] rd_byte  = sel_q ? therm_rd : ctrl_rd;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    shift_d = shift_q;
    tx_d    = tx_q;
    oe_d    = oe_q;
    ack_d   = ack_q;
    rw_d    = rw_q;
    sel_d   = sel_q;
    ctrl_d  = ctrl_q;
    therm_d = therm_q;
    if (!pg_s) begin
      state_d = ST_IDLE;
      oe_d    = 1'b0;
      sel_d   = 1'b0;
      ctrl_d  = REG_RESET;
      therm_d = REG_RESET;
    end else if (start_det) begin
      state_d = ST_ADDR;
      cnt_d   = 4'h0;
      oe_d    = 1'b0;
    end else if (stop_det) begin
      state_d = ST_IDLE;
      oe_d    = 1'b0;
    end else if (scl_rise) begin
      cnt_d   = cnt_q + 4'h1;
      shift_d = {shift_q[6:0], sda_s};
      if (state_q == ST_READ_ACK) begin
        ack_d = ~sda_s;
      end
    end else if (scl_fall) begin
      case (state_q)
        ST_ADDR: if (byte_done) begin
          rw_d = shift_q[0];
          if (addr_hit) begin
            state_d = ST_ADDR_ACK;
            oe_d    = 1'b1;
          end else begin
            state_d = ST_IDLE;
          end
        end
        ST_ADDR_ACK: begin
          cnt_d = 4'h0;
          if (rw_q) begin
            state_d = ST_READ;
            oe_d    = ~rd_byte[7];
            tx_d    = {rd_byte[6:0], 1'b0};
          end else begin
            state_d = ST_WRITE;
            oe_d    = 1'b0;
          end
        end
        ST_WRITE: if (byte_done) begin
          state_d = ST_WRITE_ACK;
          oe_d    = 1'b1;
          sel_d   = shift_q[BIT_SEL];
          if (!shift_q[BIT_SEL]) begin
            ctrl_d = shift_q & CTRL_WR_MASK;
          end else begin
            therm_d = shift_q & THERM_WR_MASK;
          end
        end
        ST_WRITE_ACK: begin
          state_d = ST_WRITE;
          cnt_d   = 4'h0;
          oe_d    = 1'b0;
        end
        ST_READ: if (byte_done) begin
          state_d = ST_READ_ACK;
          oe_d    = 1'b0;
        end else begin
          oe_d = ~tx_q[7];
          tx_d = {tx_q[6:0], 1'b0};
        end
        ST_READ_ACK: begin
          cnt_d = 4'h0;
          if (ack_q) begin
            state_d = ST_READ;
            oe_d    = ~rd_byte[7];
            tx_d    = {rd_byte[6:0], 1'b0};
          end else begin
            state_d = ST_IDLE;
            oe_d    = 1'b0;
          end
        end
        ST_IDLE: state_d = ST_IDLE;
        default: state_d = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      cnt_q   <= 4'h0;
      shift_q <= 8'h00;
      tx_q    <= 8'h00;
      oe_q    <= 1'b0;
      ack_q   <= 1'b0;
      rw_q    <= 1'b0;
      scl_q   <= 1'b0;
      sda_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      shift_q <= shift_d;
      tx_q    <= tx_d;
      oe_q    <= oe_d;
      ack_q   <= ack_d;
      rw_q    <= rw_d;
      scl_q   <= scl_s;
      sda_q   <= sda_s;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sel_q   <= 1'b0;
      ctrl_q  <= REG_RESET;
      therm_q <= REG_RESET;
    end else begin
      sel_q   <= sel_d;
      ctrl_q  <= ctrl_d;
      therm_q <= therm_d;
    end
  end

  // limiter hookup
  assign lim.enable      = ctrl_q[BIT_EN];
  assign lim.static_mode = ctrl_q[BIT_DCL];
  assign lim.overload    = ovl_s;
  assign lim.hold        = ~pg_s;

  // power stage drive; whole byte lands at once
  wire power_run = ctrl_q[BIT_EN] & ~overtemperature_flag & ~lim.output_off;

  assign sda_o         = 1'b0;
  assign sda_oe        = oe_q;
  assign supply_enable = ctrl_q[BIT_EN];
  assign boost_enable  = power_run;
  assign linreg_enable = power_run;
  assign vout_code     = {ctrl_q[BIT_LLC], ctrl_q[BIT_VOLTAGE_SELECT]};
  assign tone_on       = ctrl_q[BIT_EN]
                       & (ctrl_q[BIT_ENT] | tone_s);
  assign static_limit  = ctrl_q[BIT_DCL];

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  property p_silent_pg_low;
    !pg_s && $past(!pg_s) |-> !sda_oe && state_q == ST_IDLE;
  endproperty
  a_silent_pg_low: assert property (p_silent_pg_low)
    else $error("bus answered while power not good");

  property p_regs_zero_pg_low;
    $past(!pg_s) |-> ctrl_q == REG_RESET && therm_q == REG_RESET && !sel_q;
  endproperty
  a_regs_zero_pg_low: assert property (p_regs_zero_pg_low)
    else $error("registers not held at zero");

  property p_addr_ack;
    pg_s && !start_det && !stop_det && scl_fall && state_q == ST_ADDR
    && byte_done && addr_hit |=> state_q == ST_ADDR_ACK && sda_oe;
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("own address not acknowledged");

  property p_addr_miss;
    pg_s && !start_det && !stop_det && scl_fall && state_q == ST_ADDR
    && byte_done && !addr_hit |=> state_q == ST_IDLE && !sda_oe;
  endproperty
  a_addr_miss: assert property (p_addr_miss)
    else $error("foreign address acknowledged");

  property p_write_ctrl;
    pg_s && !start_det && !stop_det && scl_fall && state_q == ST_WRITE
    && byte_done && !shift_q[BIT_SEL]
    |=> ctrl_q == ($past(shift_q) & CTRL_WR_MASK) && !sel_q && sda_oe;
  endproperty
  a_write_ctrl: assert property (p_write_ctrl)
    else $error("control write not stored");

  property p_read_msb;
    pg_s && !start_det && !stop_det && scl_fall && state_q == ST_ADDR_ACK
    && rw_q |=> state_q == ST_READ && sda_oe == !$past(rd_byte[7]);
  endproperty
  a_read_msb: assert property (p_read_msb)
    else $error("read did not start with msb");

  property p_read_nack;
    pg_s && !start_det && !stop_det && scl_fall && state_q == ST_READ_ACK
    && !ack_q |=> state_q == ST_IDLE && !sda_oe;
  endproperty
  a_read_nack: assert property (p_read_nack)
    else $error("line not released after nack");

  property p_enable_gate;
    !ctrl_q[BIT_EN] |-> !boost_enable && !linreg_enable;
  endproperty
  a_enable_gate: assert property (p_enable_gate)
    else $error("power stage on while disabled");

  property p_tone_force;
    ctrl_q[BIT_EN] && ctrl_q[BIT_ENT] |-> tone_on;
  endproperty
  a_tone_force: assert property (p_tone_force)
    else $error("forced tone not running");

  c_write_done: cover property (state_q == ST_WRITE ##1 state_q == ST_WRITE_ACK);
  c_read_more: cover property (state_q == ST_READ_ACK && ack_q
                               ##1 state_q == ST_READ);
  c_sel_therm: cover property ($rose(sel_q));

endmodule

// file: tb_lnb_supply_i2c_control.sv
`timescale 1ns/100ps
module tb_lnb_supply_i2c_control;
  import lnbsc_pkg::*;
  logic       clk;
  logic       resetn;
  logic       scl;
  logic       sda_m;
  logic       sda_line;
  logic       sda_o;
  logic       sda_oe;
  logic       addr_sel;
  logic       power_good;
  logic       tmod;
  logic       ovl;
  logic       ovt;
  logic       supply_enable;
  logic       boost_enable;
  logic       linreg_enable;
  logic [1:0] vout_code;
  logic       tone_on;
  logic       static_limit;
  logic       ack;
  logic [6:0] dev;
  logic [7:0] d;
  int         failures;
  int         n_tests;
  int         ctrl;
  int         sp;
  int         sel;
  int         exp_q[$];

  assign sda_line = sda_m & (sda_oe ? sda_o : 1'b1);

  lnbsc_top #(.T_OFF_CYC(40), .T_ON_CYC(20)) dut (
    .clk                   (clk),
    .resetn                (resetn),
    .scl_i                 (scl),
    .sda_i                 (sda_line),
    .sda_o                 (sda_o),
    .sda_oe                (sda_oe),
    .addr_sel              (addr_sel),
    .power_good            (power_good),
    .tone_modulation_input (tmod),
    .overload_detect       (ovl),
    .overtemp_detect       (ovt),
    .supply_enable         (supply_enable),
    .boost_enable          (boost_enable),
    .linreg_enable         (linreg_enable),
    .vout_code             (vout_code),
    .tone_on               (tone_on),
    .static_limit          (static_limit)
  );

  lnbsc_host_model host (
    .clk      (clk),
    .sda_line (sda_line),
    .scl      (scl),
    .sda_m    (sda_m)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // reference register pair
  task automatic mwrite(input logic [7:0] v);
    if (v[7]) sp = v & 8'h7D;
    else ctrl = v & 8'h7E;
    sel = v[7];
  endtask

  function automatic logic [7:0] mread(input int overload_flag, input int ot);
    logic [7:0] r;
    r = sel ? 8'((sp & 8'h7D) | (ot << 1)) : 8'((ctrl & 8'h7E) | overload_flag);
    r[7] = sel[0];
    return r;
  endfunction

  task automatic wr(input logic [6:0] a, input logic [7:0] v,
                    output logic ak);
    logic k;
    host.start();
    host.wr_byte({a, 1'b0}, ak);
    if (ak) begin
      host.wr_byte(v, k);
      chk("data_ack", k, 8'h01);
    end
    host.stop();
  endtask

  // two bytes, master ack then nack
  task automatic rd(input logic [7:0] exp);
    logic       k;
    logic [7:0] v;
    exp_q.push_back(exp);
    exp_q.push_back(exp);
    host.start();
    host.wr_byte({dev, 1'b1}, k);
    chk("read_addr_ack", k, 8'h01);
    host.rd_byte(1'b1, v);
    chk("read_byte0", v, 8'(exp_q.pop_front()));
    host.rd_byte(1'b0, v);
    chk("read_byte1", v, 8'(exp_q.pop_front()));
    host.stop();
    chk("released", sda_oe, 8'h00);
  endtask

  task automatic outs(input int m, input int ot);
    logic en;
    en = ctrl[1];
    chk("supply_enable", supply_enable, en);
    chk("vout_code", vout_code, {ctrl[3], ctrl[2]});
    chk("static_limit", static_limit, ctrl[6]);
    chk("tone_on", tone_on, en & (ctrl[4] | m[0]));
    chk("boost", boost_enable, en & ~ot[0]);
    chk("linreg", linreg_enable, en & ~ot[0]);
  endtask

  initial begin
    #5_000_000;
    failures++;
    give_verdict();
  end

  initial begin
    int m;
    int ot;
    void'($urandom(43347));
    resetn     = 1'b0;
    addr_sel   = 1'($urandom);
    power_good = 1'b1;
    tmod       = 1'b0;
    ovl        = 1'b0;
    ovt        = 1'b0;
    dev        = {6'h04, addr_sel};
    ctrl       = 0;
    sp         = 0;
    sel        = 0;
    repeat (4) @(negedge clk);
    resetn = 1'b1;
    host.wait_clk(6);
    outs(0, 0);
    rd(mread(0, 0));
    for (int i = 0; i < 16; i++) begin
      d = 8'($urandom);
      d[7] = i[0];
      m = $urandom % 2;
      tmod = m[0];
      ot = $urandom % 2;
      ovt = ot[0];
      wr(dev, d, ack);
      chk("addr_ack", ack, 8'h01);
      mwrite(d);
      host.wait_clk(6);
      outs(m, ot);
      rd(mread(0, ot));
    end
    addr_sel = ~addr_sel;
    host.wait_clk(4);
    wr(dev, 8'h00, ack);
    chk("wrong_addr_ack", ack, 8'h00);
    dev = {6'h04, addr_sel};
    wr(dev, 8'h02, ack);
    chk("strap_addr_ack", ack, 8'h01);
    mwrite(8'h02);
    ovt = 1'b1;
    host.wait_clk(6);
    chk("boost_hot", boost_enable, 8'h00);
    wr(dev, 8'hFF, ack);
    mwrite(8'hFF);
    rd(mread(0, 1));
    ovt = 1'b0;
    wr(dev, 8'h42, ack);
    mwrite(8'h42);
    ovl = 1'b1;
    host.wait_clk(4);
    rd(mread(1, 0));
    ovl = 1'b0;
    host.wait_clk(4);
    rd(mread(0, 0));
    wr(dev, 8'h02, ack);
    mwrite(8'h02);
    ovl = 1'b1;
    host.wait_clk(10);
    chk("boost_off", boost_enable, 8'h00);
    rd(mread(1, 0));
    ovl = 1'b0;
    host.wait_clk(100);
    chk("boost_back", boost_enable, 8'h01);
    rd(mread(0, 0));
    power_good = 1'b0;
    host.wait_clk(6);
    chk("pg_low_enable", supply_enable, 8'h00);
    wr(dev, 8'h02, ack);
    chk("pg_low_ack", ack, 8'h00);
    power_good = 1'b1;
    ctrl = 0;
    sp   = 0;
    sel  = 0;
    host.wait_clk(6);
    rd(mread(0, 0));
    give_verdict();
  end
endmodule
